// File: rtl/flash_host.sv
// host controller driving a parallel nor flash over its bus pins
`timescale 1ns/100ps
module flash_host
(
    input wire logic clk,
    input wire logic reset_n,
    input wire flash_host_pkg::request_s req, // command from user
    input wire logic req_valid, // request present
    output logic req_ready, // request taken this cycle
    input wire logic word_mode, // width choice from user
    input wire logic accelerate, // accelerated program wanted
    output logic [15:0] rd_data, // last read result
    output logic rd_valid, // one-cycle read done pulse
    output flash_host_pkg::pins_s pins, // control pins
    output logic [21:0] addr_out, // address pins
    input wire logic [15:0] data_in, // data pins as seen
    output logic [15:0] data_out, // data pins driven
    output logic [15:0] data_oe // per-pin drive enable
);

    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {st_idle, st_read, st_write, st_recover, st_reset} state_e;
    state_e state; // sequencer state
    state_e next_state; // next sequencer state
    logic [3:0] count; // cycles in current phase
    logic [3:0] next_count; // next count
    logic [18:0] page; // page of the last taken request, in either width
    logic page_open; // page still valid under select
    logic [3:0] read_wait_cur; // wait chosen at take

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire is_idle = (state == st_idle); // ready for a request
    wire take = is_idle && req_valid; // request accepted
    wire same_page = page_open && (req.addr[21:3] == page);
    wire [3:0] read_wait = same_page ? 4'(flash_host_pkg::PACC_CYC)
                                     : 4'(flash_host_pkg::ACC_CYC);
    wire [3:0] phase_len = (state == st_read) ? read_wait_cur
                         : (state == st_write) ? 4'(flash_host_pkg::WP_CYC)
                         : (state == st_reset) ? 4'(flash_host_pkg::RP_CYC)
                         : 4'h1;
    wire phase_done = (count == phase_len); // phase finished
    // select stays low through the idle cycle after a read, so that a
    // following read in the same page is not turned into a full access
    wire keep_sel = (state == st_read) && phase_done;

    assign req_ready = take;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_count = count + flash_host_pkg::CNT_ONE;
        case (state)
            st_idle:
            begin
                next_count = flash_host_pkg::CNT_ONE;
                if (take && req.op == flash_host_pkg::op_read)
                    next_state = st_read;
                else if (take && req.op == flash_host_pkg::op_write)
                    next_state = st_write;
                else if (take)
                    next_state = st_reset;
            end
            st_read, st_write, st_reset:
            begin
                if (phase_done)
                begin
                    next_state = (state == st_read) ? st_idle : st_recover;
                    next_count = flash_host_pkg::CNT_ONE;
                end
            end
            default:
            begin
                next_state = st_idle; // one cycle with all strobes high
                next_count = flash_host_pkg::CNT_ONE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= st_idle;
            count <= 4'h0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    // request and page tracking
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_wait_cur <= 4'h1;
            page <= 19'h0_0000;
            page_open <= 1'b0;
        end
        else if (take)
        begin
            read_wait_cur <= read_wait;
            page <= req.addr[21:3];
            // page stays open only across back to back reads
            page_open <= (req.op == flash_host_pkg::op_read);
        end
        else if (state == st_idle)
        begin
            page_open <= 1'b0; // select lifted, full access next time
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    wire reading = (state == st_read);
    wire writing = (state == st_write);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
            addr_out <= 22'h00_0000;
            data_out <= flash_host_pkg::DATA_ZERO;
            data_oe <= 16'h0000;
        end
        else
        begin
            pins.chip_enable_n <= !(next_state == st_read || next_state == st_write || keep_sel);
            pins.output_enable_n <= !(next_state == st_read);
            pins.write_enable_n <= !(next_state == st_write);
            pins.reset_pin_n <= !(next_state == st_reset);
            pins.word_mode <= word_mode;
            pins.program_accelerate <= accelerate && (next_state == st_write);
            if (take)
                addr_out <= req.addr;
            if (take && req.op == flash_host_pkg::op_write)
                data_out <= word_mode ? req.data : {req.lsb, 7'h00, req.data[7:0]};
            else if (take)
                data_out <= {req.lsb, 15'h0000};
            // byte mode keeps the top pin as low address for every cycle
            data_oe <= (next_state == st_write) ? (word_mode ? 16'hFFFF : 16'h80FF)
                     : (word_mode ? 16'h0000 : 16'h8000);
        end
    end

    // read capture once access time has passed
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_data <= flash_host_pkg::DATA_ZERO;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= reading && phase_done;
            if (reading && phase_done)
                rd_data <= pins.word_mode ? data_in : {8'h00, data_in[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_read_strobes;
        @(posedge clk) disable iff (!reset_n)
        !pins.output_enable_n |-> pins.write_enable_n && !pins.chip_enable_n;
    endproperty
    a_read_strobes: assert property (p_read_strobes) else $error("read strobes wrong");

    property p_write_strobes;
        @(posedge clk) disable iff (!reset_n)
        !pins.write_enable_n |-> pins.output_enable_n && !pins.chip_enable_n;
    endproperty
    a_write_strobes: assert property (p_write_strobes) else $error("write strobes wrong");

    property p_acc_only_write;
        @(posedge clk) disable iff (!reset_n)
        pins.program_accelerate |-> !pins.write_enable_n;
    endproperty
    a_acc_only_write: assert property (p_acc_only_write) else $error("accelerate outside write");

    property p_no_drive_read;
        @(posedge clk) disable iff (!reset_n)
        !pins.output_enable_n |-> (data_oe[14:0] == 15'h0000);
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("drive during read");

    sequence s_slow_read;
        take && req.op == flash_host_pkg::op_read && !same_page;
    endsequence
    property p_full_access;
        @(posedge clk) disable iff (!reset_n)
        s_slow_read |=> !rd_valid [*2] ##1 rd_valid;
    endproperty
    a_full_access: assert property (p_full_access) else $error("full access time short");

    property p_byte_top;
        @(posedge clk) disable iff (!reset_n)
        !pins.word_mode |-> data_oe[15] && (data_oe[14:8] == 7'h00);
    endproperty
    a_byte_top: assert property (p_byte_top) else $error("byte mode pins wrong");

    property p_reset_float;
        @(posedge clk) disable iff (!reset_n)
        !pins.reset_pin_n |-> pins.chip_enable_n && pins.write_enable_n;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("strobes during reset");

    property p_word_follow;
        @(posedge clk) disable iff (!reset_n)
        ##1 (pins.word_mode == $past(word_mode));
    endproperty
    a_word_follow: assert property (p_word_follow) else $error("width pin lags");

endmodule : flash_host

// File: rtl/flash_host_pkg.sv
// package of constants and carriers for the parallel flash bus controller
package flash_host_pkg;

    // ------------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------------
    localparam int ADDR_W = 22; // word address width
    localparam int DATA_W = 16; // data bus width
    localparam int CLK_NS = 50; // clock period in ns
    localparam int ADDR_ACCESS_NS = 90; // address_access_time
    localparam int PAGE_ACCESS_NS = 25; // page_access_time
    localparam int OE_ACCESS_NS = 25; // output enable access time
    localparam int WRITE_PULSE_NS = 35; // write enable low time
    localparam int RESET_PULSE_NS = 500; // reset pin low time
    // least times round up to whole cycles
    localparam int ACC_CYC = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int PACC_CYC = (PAGE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int OE_CYC = (OE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] CNT_ONE = 4'h1; // counter step
    localparam logic [15:0] DATA_ZERO = 16'h0000; // idle data

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {op_read, op_write, op_reset} op_e;

    typedef struct packed {
        op_e op; // requested operation
        logic [21:0] addr; // word address
        logic lsb; // byte lane address, byte mode
        logic [15:0] data; // write data
    } request_s;

    typedef struct packed {
        logic chip_enable_n; // chip select
        logic output_enable_n; // output enable
        logic write_enable_n; // write enable
        logic reset_pin_n; // hardware reset
        logic word_mode; // width select, high for word
        logic program_accelerate; // high voltage request
    } pins_s;

endpackage : flash_host_pkg

// File: verification/flash_model.sv
// behavioural model of the parallel nor flash facing the controller
`timescale 1ns/100ps
module flash_model
(
    input wire flash_host_pkg::pins_s pins,
    input wire logic [21:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    output logic [15:0] data_in,
    output logic bad_bus
);
    // --------------------------------------------------------------
    // array, timing and bus state
    // --------------------------------------------------------------
    logic [15:0] mem [logic [21:0]]; // programmed words
    logic [15:0] fl = 16'h5a5a; // undriven pins flip every step
    logic [15:0] word; // array word at the address
    logic [15:0] val; // value the device drives
    logic [15:0] drv; // pins the device drives
    logic [18:0] pg; // page of the last finished read
    logic rd; // read cycle decoded
    logic wr; // write cycle decoded
    logic page_ok = 1'b0; // page open for fast access
    realtime t_a = 0.0; // last address change
    realtime t_o = 0.0; // last output enable fall
    realtime need = 90.0; // access time in force
    initial data_in = 16'h0000;
    initial bad_bus = 1'b0;
    // select fall starts a full random access
    always @(negedge pins.chip_enable_n)
    begin
        page_ok = 1'b0;
        need = flash_host_pkg::ADDR_ACCESS_NS;
        t_a = $realtime;
    end
    // moves inside an open page are fast
    always @(addr_out)
    begin
        if (page_ok && addr_out[21:3] == pg)
            need = flash_host_pkg::PAGE_ACCESS_NS;
        else
            need = flash_host_pkg::ADDR_ACCESS_NS;
        t_a = $realtime;
    end
    // output enable fall restarts its own access time
    always @(negedge pins.output_enable_n)
        t_o = $realtime;
    // pin behaviour, stepped every nanosecond
    always
    begin
        #1;
        fl = ~fl;
        rd = !pins.chip_enable_n && !pins.output_enable_n && pins.write_enable_n
            && pins.reset_pin_n;
        wr = !pins.chip_enable_n && pins.output_enable_n && !pins.write_enable_n
            && pins.reset_pin_n;
        word = mem.exists(addr_out) ? mem[addr_out] : addr_out[15:0] ^ 16'ha5c3;
        val = pins.word_mode ? word : {8'h00, data_in[15] ? word[15:8] : word[7:0]};
        drv = !rd ? 16'h0000 : pins.word_mode ? 16'hffff : 16'h00ff;
        if ($realtime < t_a + need || $realtime < t_o + flash_host_pkg::OE_ACCESS_NS)
            val = ~val;
        else if (rd)
        begin
            page_ok = 1'b1;
            pg = addr_out[21:3];
        end
        if (wr && pins.word_mode)
            mem[addr_out] = data_out;
        if ((|(drv & data_oe)) || (pins.program_accelerate && !wr))
            bad_bus = 1'b1;
        data_in = (data_oe & data_out) | (~data_oe & drv & val) | (~data_oe & ~drv & fl);
    end
endmodule : flash_model

// File: verification/testbench.sv
// self-checking bench for the flash bus controller against a device model
`timescale 1ns/100ps
module testbench;
    logic clk; // bus clock
    logic reset_n; // controller reset
    flash_host_pkg::request_s req; // request to controller
    flash_host_pkg::pins_s pins; // control pins
    logic req_valid, req_ready, word_mode, accelerate, rd_valid, bad_bus;
    logic [15:0] rd_data, data_in, data_out, data_oe;
    logic [21:0] addr_out;
    int bad_count = 0; // mismatches
    int n_compared = 0; // comparisons
    flash_host DUT (.clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .word_mode(word_mode), .accelerate(accelerate),
        .rd_data(rd_data), .rd_valid(rd_valid), .pins(pins), .addr_out(addr_out),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    flash_model dev (.pins(pins), .addr_out(addr_out), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .bad_bus(bad_bus));
    // compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // present a request, at a rising edge
    task put(input flash_host_pkg::op_e op, input logic [21:0] a, input logic [15:0] d);
        req <= '{op, a, d[15], d};
        req_valid <= 1'b1;
    endtask : put
    // wait, bounded, until the take edge has passed
    task take();
        int i;
        i = 0;
        #1;
        while (req_ready !== 1'b1 && i < 40)
        begin
            @(negedge clk);
            i++;
        end
        check(req_ready, 1'b1);
        @(posedge clk);
    endtask : take
    // wait for read data, judge latency and value
    task get(input logic [15:0] exp, input int lat);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rd_valid !== 1'b1 && n < 20);
        check(n, lat);
        check(rd_data, exp);
    endtask : get
    // array content the model holds before any program
    function automatic logic [15:0] arr(input logic [21:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction : arr
    // one full read, then a page run across a page boundary
    task t_reads();
        @(posedge clk);
        put(flash_host_pkg::op_read, 22'h00_1230, 16'h0000);
        take();
        put(flash_host_pkg::op_read, 22'h00_1237, 16'h0000);
        get(arr(22'h00_1230), 3);
        take();
        put(flash_host_pkg::op_read, 22'h00_1238, 16'h0000);
        get(arr(22'h00_1237), 2);
        take();
        req_valid <= 1'b0;
        get(arr(22'h00_1238), 3);
        @(posedge clk);
        put(flash_host_pkg::op_read, 22'h00_1239, 16'h0000);
        take();
        req_valid <= 1'b0;
        get(arr(22'h00_1239), 3);
    endtask : t_reads
    // byte reads, low address bit on the top data pin
    task t_byte();
        logic [15:0] w;
        w = arr(22'h00_0456);
        for (int l = 0; l < 2; l++)
        begin
            @(posedge clk);
            word_mode <= 1'b0;
            put(flash_host_pkg::op_read, 22'h00_0456, {l[0], 15'h0000});
            take();
            req_valid <= 1'b0;
            @(negedge clk);
            check({pins.word_mode, data_oe[15], data_out[15]}, {2'h1, l[0]});
            get({8'h00, l[0] ? w[15:8] : w[7:0]}, 2);
        end
        check(pins.output_enable_n, 1'b1);
        @(posedge clk);
        word_mode <= 1'b1;
    endtask : t_byte
    // accelerated write, then read back
    task t_write();
        @(posedge clk);
        accelerate <= 1'b1;
        put(flash_host_pkg::op_write, 22'h00_2000, 16'h1234);
        take();
        req_valid <= 1'b0;
        @(negedge clk);
        check(pins, 6'h17);
        check({data_oe, data_out}, 32'hffff_1234);
        check(addr_out, 22'h00_2000);
        @(negedge clk);
        check(pins.program_accelerate, 1'b0);
        @(posedge clk);
        accelerate <= 1'b0;
        put(flash_host_pkg::op_read, 22'h00_2000, 16'h0000);
        take();
        req_valid <= 1'b0;
        get(16'h1234, 3);
        check(bad_bus, 1'b0);
    endtask : t_write
    // reset pulse, then array read again
    task t_reset();
        @(posedge clk);
        put(flash_host_pkg::op_reset, 22'h00_0000, 16'h0000);
        take();
        req_valid <= 1'b0;
        @(negedge clk);
        check(pins.reset_pin_n, 1'b0);
        @(posedge clk);
        put(flash_host_pkg::op_read, 22'h00_2000, 16'h0000);
        take();
        req_valid <= 1'b0;
        get(16'h1234, 3);
    endtask : t_reset
    // counts, verdict and end of run
    task final_report();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog cuts a hang short
    initial
    begin
        #(50 * 3000);
        bad_count++;
        final_report();
    end
    // main sequence
    initial
    begin
        reset_n = 1'b0;
        req = '0;
        req_valid = 1'b0;
        word_mode = 1'b1;
        accelerate = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        t_reads();
        t_byte();
        t_write();
        t_reset();
        final_report();
    end
endmodule : testbench
